// ### core/sideband_pkg.sv
// constants, register maps and state types of the sideband control block
package sideband_pkg;
  // clock and timing figures
  localparam int CLOCK_MHZ = 200;
  localparam int INIT_TIME_MS = 2000;
  localparam longint INIT_CYCLES = longint'(INIT_TIME_MS) * 1000 * CLOCK_MHZ;
  localparam longint INIT_SETTLE_CYCLES = INIT_CYCLES / 2;
  localparam int INIT_COUNT_W = 29;
  localparam int RESET_PULSE_US = 2;
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_US * CLOCK_MHZ;
  localparam int RESET_COUNT_W = 9;

  // 2-wire slave address, read/write bit appended below it
  localparam logic [6:0] SERIAL_ADDRESS = 7'h50;

  // AHB byte offsets, one word each
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] CONTROL_OFFSET = 8'h0C;

  // 2-wire byte addresses of the same registers
  localparam logic [7:0] STATUS_BYTE = 8'h02;
  localparam logic [7:0] FLAGS_BYTE = 8'h03;
  localparam logic [7:0] CONTROL_BYTE = 8'h5D;
  localparam logic [7:0] MASK_BYTE = 8'h64;

  // field positions
  localparam int DATA_NOT_READY_BIT = 0;
  localparam int LOW_POWER_BIT = 1;
  localparam int POWER_DOWN_BIT = 0;
  localparam int FLAG_READY_BIT = 7;
  localparam int CONDITION_COUNT = 3;

  // values after reset
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [4:0] PIN_SYNC_RESET = 5'h0F;

  // positions in the synchronised pin vector
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_RESET = 2;
  localparam int PIN_SELECT = 3;
  localparam int PIN_LOW_POWER = 4;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_ADDR = 3'b001,
    SER_ADDR_ACK = 3'b010,
    SER_WRITE = 3'b011,
    SER_WRITE_ACK = 3'b100,
    SER_READ = 3'b101,
    SER_READ_ACK = 3'b110
  } serial_state_type;
endpackage

// ### core/reg_bus_if.sv
// register access strobes between the bus slave and the register owner
`timescale 1ns/100ps
interface reg_bus_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport master (output wr, output rd, output addr, output wdata, input rdata);
  modport target (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// ### core/pin_sync.sv
// three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] differ = stage2 ^ stage3;
  // stage1 feeds stage2 only; a disagreement holds the old value
  wire [WIDTH-1:0] next_pin_out = (~differ & stage3) | (differ & pin_out);

  // shift chain and filtered output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      pin_out <= RESET_VALUE;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_out <= next_pin_out;
    end
  end
endmodule

// ### core/ahb_slave.sv
// AHB-Lite slave with one wait state, turning transfers into register strobes
`timescale 1ns/100ps
module ahb_slave (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  reg_bus_if.master regs
);
  logic pending;
  logic pend_write;
  logic pend_word;
  logic [7:0] pend_addr;

  // only aligned word transfers reach the registers; upper address bits mirror
  wire accept = hsel & hready & htrans[1];
  wire word_access = (hsize == 3'h2) & (haddr[1:0] == 2'h0);

  // strobes fire in the data phase, when hwdata is on the bus
  assign regs.addr = pend_addr;
  assign regs.wdata = hwdata;
  assign regs.wr = pending & pend_write & pend_word;
  assign regs.rd = pending & ~pend_write & pend_word;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending <= 1'b0;
      pend_write <= 1'b0;
      pend_word <= 1'b0;
      pend_addr <= 8'h00;
    end else begin
      pending <= accept;
      if (accept) begin
        pend_write <= hwrite;
        pend_word <= word_access;
        pend_addr <= haddr[7:0];
      end
    end
  end

  // one wait state keeps hrdata on a flop; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= ~accept;
      if (pending) begin
        hrdata <= (pend_word & ~pend_write) ? regs.rdata : 32'h00000000;
      end
    end
  end
endmodule

// ### core/sideband_control.sv
// sideband control: start-up timing, reset pulse check, flags, interrupt and 2-wire slave
//
// Function
// - functional within 2000 ms after any start
// - reset counts only when low over 2 us
// - serial bus answers within 2000 ms of power-on
// - clear not-ready bit and raise interrupt
// - functional within 2000 ms after reset release
// - low-power pin lowers power within 100 us
// - condition sets flag, interrupt low within 200 ms
// - read clears flags, interrupt released in 500 us
// - receive signal loss flags within 100 ms
// - set mask stops interrupt within 100 ms
// - cleared mask resumes interrupt within 100 ms
// - select asserted, serial answers within 100 us
// - select released, serial silent within 100 us
// - power-down bit lowers power within 100 ms
// - power-down cleared, functional within 300 ms; code sets no ready flag and raises no interrupt on clearing
// - functional shown by interrupt with ready bit
// - access latencies count from stop clock edge
// - serial slave address is 1010000
`timescale 1ns/100ps
module sideband_control
  import sideband_pkg::*;
#(
  parameter logic [INIT_COUNT_W-1:0] INIT_WAIT_CYCLES = INIT_COUNT_W'(INIT_SETTLE_CYCLES)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic module_reset_n,
  input wire logic module_select_n,
  input wire logic low_power_request,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [CONDITION_COUNT-1:0] flag_condition,
  output logic interrupt_out_n,
  output logic module_present_n,
  output logic low_power_active
);
  // pin synchronisation
  logic [4:0] pins;
  wire [4:0] pins_raw = {low_power_request, module_select_n, module_reset_n, sda_in, scl_in};
  wire scl = pins[PIN_SCL];
  wire sda = pins[PIN_SDA];
  wire reset_pin_n = pins[PIN_RESET];
  wire select_n = pins[PIN_SELECT];
  wire low_power_pin = pins[PIN_LOW_POWER];

  pin_sync #(
    .WIDTH(5),
    .RESET_VALUE(PIN_SYNC_RESET)
  ) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  // software register bus
  reg_bus_if regs_bus();

  ahb_slave u_ahb_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .regs(regs_bus.master)
  );

  // state declarations
  logic [RESET_COUNT_W-1:0] reset_low_count;
  logic [INIT_COUNT_W-1:0] init_count;
  logic data_not_ready;
  logic [CONDITION_COUNT-1:0] condition_prev;
  logic [7:0] flags;
  logic [7:0] mask;
  logic power_down;
  serial_state_type state;
  logic scl_prev;
  logic sda_prev;
  logic [2:0] bit_count;
  logic byte_full;
  logic have_pointer;
  logic read_mode;
  logic drive_low;
  logic [7:0] shift_byte;
  logic [7:0] pointer;

  // reset pulse qualification: short glitches on the pin are ignored
  wire module_in_reset = reset_low_count > RESET_COUNT_W'(RESET_PULSE_CYCLES);

  // low-time counter saturates once the pulse has qualified
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_low_count <= '0;
    end else if (reset_pin_n) begin
      reset_low_count <= '0;
    end else if (!module_in_reset) begin
      reset_low_count <= reset_low_count + 1'b1;
    end
  end

  // start-up timer; settles well inside the limit so the interrupt flop fits too
  wire init_done = data_not_ready & (init_count == INIT_WAIT_CYCLES - 1'b1);

  // not-ready bit: set by power-on or a qualified reset, cleared when settled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_count <= '0;
      data_not_ready <= 1'b1;
    end else if (module_in_reset) begin
      init_count <= '0;
      data_not_ready <= 1'b1;
    end else if (init_done) begin
      data_not_ready <= 1'b0;
    end else if (data_not_ready) begin
      init_count <= init_count + 1'b1;
    end
  end

  // conditions come from logic on hclk, so no synchroniser; rising edges set flags
  wire [CONDITION_COUNT-1:0] condition_rise = flag_condition & ~condition_prev;
  wire [7:0] flag_set = {init_done, {(7 - CONDITION_COUNT){1'b0}}, condition_rise};

  // serial strobes are decoded further down with the serial engine
  wire serial_rd;
  wire serial_wr;
  wire [7:0] serial_rdata;

  // register write and read decode for both access paths
  wire ahb_mask_wr = regs_bus.wr & (regs_bus.addr == MASK_OFFSET);
  wire ahb_control_wr = regs_bus.wr & (regs_bus.addr == CONTROL_OFFSET);
  wire ahb_flags_rd = regs_bus.rd & (regs_bus.addr == FLAGS_OFFSET);
  wire serial_mask_wr = serial_wr & (pointer == MASK_BYTE);
  wire serial_control_wr = serial_wr & (pointer == CONTROL_BYTE);
  wire serial_flags_rd = serial_rd & (pointer == FLAGS_BYTE);
  wire flags_read = ahb_flags_rd | serial_flags_rd;

  // a flag raised in the cycle of its read stays set, so no event is lost
  wire [7:0] next_flags = (flags & ~{8{flags_read}}) | flag_set;

  // software on AHB wins when both paths write in the same cycle
  wire [7:0] next_mask = ahb_mask_wr ? regs_bus.wdata[7:0] : (serial_mask_wr ? shift_byte : mask);
  wire next_power_down = ahb_control_wr ? regs_bus.wdata[POWER_DOWN_BIT] :
                         (serial_control_wr ? shift_byte[POWER_DOWN_BIT] : power_down);

  // flags, masks and control bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      condition_prev <= '0;
      flags <= FLAGS_RESET;
      mask <= MASK_RESET;
      power_down <= 1'b0;
    end else if (module_in_reset) begin
      condition_prev <= '0;
      flags <= FLAGS_RESET;
      mask <= MASK_RESET;
      power_down <= 1'b0;
    end else begin
      condition_prev <= flag_condition;
      flags <= next_flags;
      mask <= next_mask;
      power_down <= next_power_down;
    end
  end

  // read multiplexers; status shows readiness and the power level in effect
  wire [7:0] status_value = {6'h00, low_power_active, data_not_ready};
  wire [7:0] ahb_byte = (regs_bus.addr == STATUS_OFFSET) ? status_value :
                        (regs_bus.addr == FLAGS_OFFSET) ? flags :
                        (regs_bus.addr == MASK_OFFSET) ? mask :
                        (regs_bus.addr == CONTROL_OFFSET) ? {7'h00, power_down} : 8'h00;
  assign regs_bus.rdata = {24'h000000, ahb_byte};
  assign serial_rdata = (pointer == STATUS_BYTE) ? status_value :
                        (pointer == FLAGS_BYTE) ? flags :
                        (pointer == MASK_BYTE) ? mask :
                        (pointer == CONTROL_BYTE) ? {7'h00, power_down} : 8'h00;

  // interrupt level: any unmasked flag pending pulls it low
  wire interrupt_pending = |(flags & ~mask);

  // pin outputs, each one flop after its cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_out_n <= 1'b1;
      low_power_active <= 1'b0;
      module_present_n <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      interrupt_out_n <= ~interrupt_pending;
      low_power_active <= low_power_pin | power_down;
      module_present_n <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= drive_low;
    end
  end

  // 2-wire slave: select gates it, and a qualified reset silences it
  wire select_ok = ~select_n & ~module_in_reset;
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire bus_start = scl & scl_prev & sda_prev & ~sda;
  wire bus_stop = scl & scl_prev & ~sda_prev & sda;
  wire address_match = shift_byte[7:1] == SERIAL_ADDRESS;
  wire load_read = scl_fall & select_ok & (((state == SER_ADDR_ACK) & read_mode) | (state == SER_READ_ACK));
  assign serial_rd = load_read;
  assign serial_wr = scl_fall & select_ok & (state == SER_WRITE) & byte_full & have_pointer;

  // edge history of the filtered bus lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  // bit engine: sample on scl rise, change sda on scl fall; no clock stretching
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SER_IDLE;
      bit_count <= 3'h0;
      byte_full <= 1'b0;
      have_pointer <= 1'b0;
      read_mode <= 1'b0;
      drive_low <= 1'b0;
      shift_byte <= 8'h00;
      pointer <= 8'h00;
    end else if (!select_ok || bus_stop) begin
      state <= SER_IDLE;
      drive_low <= 1'b0;
    end else if (bus_start) begin
      state <= SER_ADDR;
      bit_count <= 3'h0;
      byte_full <= 1'b0;
      have_pointer <= 1'b0;
      drive_low <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        SER_ADDR, SER_WRITE: begin
          shift_byte <= {shift_byte[6:0], sda};
          bit_count <= bit_count + 1'b1;
          byte_full <= (bit_count == 3'h7);
        end
        SER_READ_ACK: begin
          if (sda) begin
            state <= SER_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        SER_ADDR: begin
          if (byte_full) begin
            byte_full <= 1'b0;
            if (address_match) begin
              read_mode <= shift_byte[0];
              drive_low <= 1'b1;
              state <= SER_ADDR_ACK;
            end else begin
              state <= SER_IDLE;
            end
          end
        end
        SER_ADDR_ACK, SER_READ_ACK: begin
          bit_count <= 3'h0;
          if (load_read) begin
            shift_byte <= serial_rdata;
            drive_low <= ~serial_rdata[7];
            state <= SER_READ;
          end else begin
            drive_low <= 1'b0;
            state <= SER_WRITE;
          end
        end
        SER_WRITE: begin
          if (byte_full) begin
            byte_full <= 1'b0;
            drive_low <= 1'b1;
            state <= SER_WRITE_ACK;
            have_pointer <= 1'b1;
            // first byte sets the pointer, later bytes store and advance it
            pointer <= have_pointer ? pointer + 1'b1 : shift_byte;
          end
        end
        SER_WRITE_ACK: begin
          drive_low <= 1'b0;
          bit_count <= 3'h0;
          state <= SER_WRITE;
        end
        SER_READ: begin
          if (bit_count == 3'h7) begin
            drive_low <= 1'b0;
            pointer <= pointer + 1'b1;
            state <= SER_READ_ACK;
          end else begin
            shift_byte <= {shift_byte[6:0], 1'b0};
            drive_low <= ~shift_byte[6];
            bit_count <= bit_count + 1'b1;
          end
        end
        default: begin
          state <= SER_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verif/sideband_control_props.sv
// port-level assertions for the sideband control block
`timescale 1ns/100ps
module sideband_control_props
  import sideband_pkg::*;
#(
  parameter logic [INIT_COUNT_W-1:0] INIT_WAIT_CYCLES = 29'h32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic module_select_n,
  input wire logic low_power_request,
  input wire logic sda_oe,
  input wire logic interrupt_out_n,
  input wire logic module_present_n,
  input wire logic low_power_active
);
  // cycles since bus reset release, saturating so it never wraps into the init window
  logic [31:0] up_cycles;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      up_cycles <= '0;
    else if (up_cycles != 32'hFFFFFFFF)
      up_cycles <= up_cycles + 32'h1;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_present_low: assert property (module_present_n == 1'b0)
    else $error("presence output left low level");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved without a transfer");
  chk_pin_lowpower: assert property (low_power_request [*8] |-> low_power_active)
    else $error("low-power pin not followed");
  chk_deselect_quiet: assert property (module_select_n [*8] |-> !sda_oe)
    else $error("serial data driven while deselected");
  chk_init_done: assert property (up_cycles == 32'(INIT_WAIT_CYCLES) + 32'h8 |-> !interrupt_out_n)
    else $error("not functional after init time");
  chk_init_wait: assert property (up_cycles + 32'h2 < 32'(INIT_WAIT_CYCLES) |-> interrupt_out_n)
    else $error("interrupt before data ready");
endmodule

bind sideband_control sideband_control_props #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES)) props_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .module_select_n(module_select_n),
  .low_power_request(low_power_request), .sda_oe(sda_oe), .interrupt_out_n(interrupt_out_n),
  .module_present_n(module_present_n), .low_power_active(low_power_active)
);

// ### verif/serial_host_model.sv
// behavioural host 2-wire master; clock stands high between frames
`timescale 1ns/100ps
module serial_host_model (
  output logic scl,
  output logic sda_drive,
  input wire logic sda_line
);
  localparam int HALF = 40;
  initial begin
    scl = 1'b1;
    sda_drive = 1'b0;
  end
  // quarter waits keep data edges apart from clock edges through the synchroniser
  task automatic start_bit();
    #(HALF / 2);
    sda_drive = 1'b0;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_drive = 1'b1;
    #HALF;
    scl = 1'b0;
  endtask
  task automatic stop_bit();
    #(HALF / 2);
    sda_drive = 1'b1;
    #HALF;
    scl = 1'b1;
    #HALF;
    sda_drive = 1'b0;
    #HALF;
  endtask
  // one bit: data set mid-low, sampled at end of high
  task automatic bit_cycle(input logic b, output logic got);
    #(HALF / 2);
    sda_drive = !b;
    #(HALF / 2);
    scl = 1'b1;
    #HALF;
    got = sda_line;
    scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] val, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--) bit_cycle(val[i], got);
    bit_cycle(1'b1, got);
    ack = !got;
  endtask
  task automatic take_byte(input logic last, output logic [7:0] val);
    logic got;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, got);
      val[i] = got;
    end
    bit_cycle(last, got); // nack on the last byte
  endtask
  // pointer then one data byte; acked only if every byte was acked
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] val, output logic acked);
    logic a0, a1, a2;
    // step off the hclk edge so the synchroniser never races a pin change
    #1;
    start_bit();
    send_byte({dev, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(val, a2);
    stop_bit();
    acked = a0 & a1 & a2;
  endtask
  // random read: pointer, repeated start, one byte then nack
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val, output logic acked);
    logic a0, a1, a2;
    #1;
    start_bit();
    send_byte({dev, 1'b0}, a0);
    send_byte(ptr, a1);
    start_bit();
    send_byte({dev, 1'b1}, a2);
    take_byte(1'b1, val);
    stop_bit();
    acked = a0 & a1 & a2;
  endtask
endmodule

// ### verif/sideband_control_bench.sv
// self-checking bench for the sideband control block
`timescale 1ns/100ps
module sideband_control_bench
  import sideband_pkg::*;
;
  localparam int INIT_WAIT = 50;
  localparam logic [6:0] DEV = 7'h50;
  logic hclk, hresetn, hsel, hwrite, module_reset_n, module_select_n, low_power_request;
  logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
  logic [1:0] htrans;
  logic [2:0] hsize, flag_condition;
  logic hreadyout, hresp, sda_out, sda_oe, interrupt_out_n, module_present_n, low_power_active;
  logic scl, host_oe, ack;
  logic [7:0] rbyte, mask_val;
  wire sda_line;
  int num_errors = 0;
  int n_checks = 0;
  // open-drain data line with pull-up
  assign sda_line = !(sda_oe | host_oe);

  sideband_control #(.INIT_WAIT_CYCLES(INIT_COUNT_W'(INIT_WAIT))) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .module_reset_n(module_reset_n), .module_select_n(module_select_n),
    .low_power_request(low_power_request), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .flag_condition(flag_condition), .interrupt_out_n(interrupt_out_n),
    .module_present_n(module_present_n), .low_power_active(low_power_active)
  );
  serial_host_model host_u (.scl(scl), .sda_drive(host_oe), .sda_line(sda_line));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] status_word(input logic nr, input logic lp);
    return {30'h0, lp, nr};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // wait for hready sampled high at an edge; only the watchdog ends a hang
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic ahb(input logic [7:0] addr, input logic wr, input logic [31:0] wd);
    haddr <= {24'h0, addr};
    hwrite <= wr;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    module_reset_n = 1'b1;
    module_select_n = 1'b1;
    low_power_request = 1'b0;
    flag_condition = '0;
    lfsr = 32'h5CA3;
    cycles(5);
    hresetn <= 1'b1;
    cycles(1);
    // start-up: not ready, then ready event
    ahb(STATUS_OFFSET, 1'b0, '0);
    check(rd, status_word(1'b1, 1'b0));
    cycles(INIT_WAIT + 10);
    check(32'(interrupt_out_n), 32'h0);
    ahb(STATUS_OFFSET, 1'b0, '0);
    check(rd, status_word(1'b0, 1'b0));
    ahb(FLAGS_OFFSET, 1'b0, '0);
    check(rd, 32'h80);
    cycles(4);
    check(32'(interrupt_out_n), 32'h1);
    // every condition input sets its own flag
    for (int n = 0; n < CONDITION_COUNT; n++) begin
      flag_condition[n] <= 1'b1;
      cycles(4);
      check(32'(interrupt_out_n), 32'h0);
      flag_condition[n] <= 1'b0;
      ahb(FLAGS_OFFSET, 1'b0, '0);
      check(rd, 32'h1 << n);
      ahb(FLAGS_OFFSET, 1'b0, '0);
      check(rd, 32'h0);
      cycles(4);
      check(32'(interrupt_out_n), 32'h1);
    end
    // mask read-back, then masking holds off a pending flag
    lfsr = next_rand(lfsr);
    ahb(MASK_OFFSET, 1'b1, lfsr);
    ahb(MASK_OFFSET, 1'b0, '0);
    check(rd, {24'h0, lfsr[7:0]});
    ahb(MASK_OFFSET, 1'b1, 32'h1);
    flag_condition[0] <= 1'b1;
    cycles(6);
    check(32'(interrupt_out_n), 32'h1);
    ahb(MASK_OFFSET, 1'b1, 32'h0);
    cycles(4);
    check(32'(interrupt_out_n), 32'h0);
    flag_condition[0] <= 1'b0;
    ahb(FLAGS_OFFSET, 1'b0, '0);
    check(rd, 32'h1);
    // pin and software power-down
    low_power_request <= 1'b1;
    cycles(8);
    check(32'(low_power_active), 32'h1);
    low_power_request <= 1'b0;
    cycles(8);
    check(32'(low_power_active), 32'h0);
    ahb(CONTROL_OFFSET, 1'b1, 32'h1);
    cycles(2);
    check(32'(low_power_active), 32'h1);
    ahb(STATUS_OFFSET, 1'b0, '0);
    check(rd, status_word(1'b0, 1'b1));
    ahb(CONTROL_OFFSET, 1'b1, 32'h0);
    cycles(2);
    check(32'(low_power_active), 32'h0);
    ahb(8'h10, 1'b0, '0);
    check(rd, 32'h0);
    // serial access while selected, wrong address, then deselected
    module_select_n <= 1'b0;
    cycles(10);
    lfsr = next_rand(lfsr);
    mask_val = lfsr[7:0] | 8'h01;
    host_u.write_reg(DEV, MASK_BYTE, mask_val, ack);
    check(32'(ack), 32'h1);
    host_u.read_reg(DEV, MASK_BYTE, rbyte, ack);
    check({24'h0, rbyte}, {24'h0, mask_val});
    check(32'(sda_out), 32'h0);
    host_u.write_reg(DEV + 7'h1, MASK_BYTE, 8'h00, ack);
    check(32'(ack), 32'h0);
    module_select_n <= 1'b1;
    cycles(10);
    host_u.write_reg(DEV, MASK_BYTE, 8'h00, ack);
    check(32'(ack), 32'h0);
    ahb(MASK_OFFSET, 1'b0, '0);
    check(rd, {24'h0, mask_val});
    // short reset pulse ignored, long one restarts init
    module_reset_n <= 1'b0;
    cycles(100);
    module_reset_n <= 1'b1;
    cycles(10);
    ahb(MASK_OFFSET, 1'b0, '0);
    check(rd, {24'h0, mask_val});
    module_reset_n <= 1'b0;
    cycles(500);
    module_reset_n <= 1'b1;
    cycles(10);
    ahb(MASK_OFFSET, 1'b0, '0);
    check(rd, 32'h0);
    ahb(STATUS_OFFSET, 1'b0, '0);
    check(rd, status_word(1'b1, 1'b0));
    cycles(INIT_WAIT + 10);
    check(32'(interrupt_out_n), 32'h0);
    stop_test();
  end
endmodule
